// ===== design/modem_cfg_defines.svh
// register offsets, field positions, reset values and constants for the modem configuration bank
// Function
// - deviation bit 7 enables gaussian transmit shaping, reset value 1
// - deviation bits 6:4 hold tx_dev_exponent, reset value 6
// - deviation bits 3:0 hold tx_dev_mantissa, reset value 8
// - lower band deviation is fref times mantissa times 2^(exponent-16)
// - upper band deviation is fref times mantissa times 2^(exponent-15)
// - zero tx_dev_mantissa selects on-off keying for receive and transmit
// - settling field zero turns frequency control off, zero average used
// - settling 1,2,3 average over 1,2,4 bit pairs; reset value 2
// - afc bits 5:4 rx_dev_exponent reset 1; bits 3:0 rx_dev_mantissa reset 12
// - expected receive deviation is baud times mantissa times 2^(exponent-3) over 3
// - filter bit 7 bypasses analog filter, reset 0, advised from 76.8 kbaud
// - filter bits 6:5 decimator_input_shift, reset 0, advised by divisor value
// - filter bits 2:0 decimation_divisor, reset 0, divisor is value plus one
// - channel filter bandwidth is 307.2 khz over the decimation divisor
// - baud rate equals modem clock frequency divided by 8
`ifndef MODEM_CFG_DEFINES_SVH
`define MODEM_CFG_DEFINES_SVH
`define ADDR_W            8
`define OFS_TX_DEV        8'h0e
`define OFS_FREQ_CORR     8'h0f
`define OFS_CHAN_FILT     8'h10
`define RST_TX_DEV        8'he8
`define RST_FREQ_CORR     8'h9c
`define RST_CHAN_FILT     8'h00
`define RST_TX_SHIFT      5'h0a
`define RST_RX_SHIFT      3'h2
`define FILT_WR_MASK      8'he7
`define BAUD_DIV          4'h8
`define BAUD_DIV_LAST     4'h7
`define TX_EXP_OFS_LO     5'h10
`define TX_EXP_OFS_HI     5'h0f
`define RX_EXP_OFS        3'h3
`define FILT_BW_BASE_HZ   19'h4b000
`endif

// ===== design/modem_cfg_pkg.sv
// types shared by the modem configuration bank
package modem_cfg_pkg;
	typedef enum logic [1:0] {
		SETTLE_OFF  = 2'h0,
		SETTLE_FAST = 2'h1,
		SETTLE_MED  = 2'h2,
		SETTLE_SLOW = 2'h3
	} settle_t;
	typedef enum logic [2:0] {
		DIV_IDLE = 3'b001,
		DIV_RUN  = 3'b010,
		DIV_TICK = 3'b100
	} div_state_t;
endpackage : modem_cfg_pkg

// ===== design/rate_divider.sv
// programmable divider producing a one-cycle enable every n input enables
`timescale 1ns/100ps
`include "modem_cfg_defines.svh"
module rate_divider
	import modem_cfg_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       en_in,
	input  wire logic [3:0] last,
	output logic            tick
);
	typedef struct packed {
		logic [3:0] cnt;
		logic       tick;
	} div_t;
	div_t st_reg;
	div_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (en_in) begin
			if (st_reg.cnt >= last) begin
				st_next.cnt = 4'h0;
				st_next.tick = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick = st_reg.tick;
endmodule : rate_divider

// ===== design/afc_averager.sv
// frequency control averager: mean of the last 2, 4 or 8 frequency samples (1, 2, 4 bit pairs)
`timescale 1ns/100ps
`include "modem_cfg_defines.svh"
module afc_averager
	import modem_cfg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        sample_en,
	input  wire logic [11:0] freq_sample,
	input  wire logic [1:0]  settling,
	output logic [11:0]      freq_avg
);
	typedef struct packed {
		logic [7:0][11:0] hist;
		logic [11:0]      avg;
	} avg_st_t;
	avg_st_t     st_reg;
	avg_st_t     st_next;
	logic [14:0] sum2;
	logic [14:0] sum4;
	logic [14:0] sum8;

	always_comb begin
		sum2 = 15'(st_reg.hist[0]) + 15'(st_reg.hist[1]);
		sum4 = sum2 + 15'(st_reg.hist[2]) + 15'(st_reg.hist[3]);
		sum8 = sum4 + 15'(st_reg.hist[4]) + 15'(st_reg.hist[5])
			+ 15'(st_reg.hist[6]) + 15'(st_reg.hist[7]);
		st_next = st_reg;
		if (sample_en) begin
			st_next.hist = {st_reg.hist[6:0], freq_sample};
		end
		unique case (settle_t'(settling))
			SETTLE_OFF:  st_next.avg = 12'h000;
			SETTLE_FAST: st_next.avg = sum2[12:1];
			SETTLE_MED:  st_next.avg = sum4[13:2];
			SETTLE_SLOW: st_next.avg = sum8[14:3];
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign freq_avg = st_reg.avg;
endmodule : afc_averager

// ===== design/modem_cfg_regs.sv
// modem configuration register bank with derived modem controls
`timescale 1ns/100ps
`include "modem_cfg_defines.svh"
module modem_cfg_regs
	import modem_cfg_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic [`ADDR_W-1:0] addr,
	input  wire logic [7:0]        wdata,
	input  wire logic              wr_en,
	input  wire logic              rd_en,
	output logic [7:0]             rdata,
	input  wire logic              upper_band,
	input  wire logic              modem_clk_en,
	input  wire logic [11:0]       freq_sample,
	output logic                   gauss_shaping_on,
	output logic                   ook_mode,
	output logic [4:0]             tx_dev_shift,
	output logic [3:0]             tx_dev_mantissa,
	output logic [2:0]             rx_dev_shift,
	output logic [3:0]             rx_dev_mantissa,
	output logic                   baud_tick,
	output logic [11:0]            freq_avg,
	output logic                   analog_filter_skip,
	output logic [1:0]             decimator_input_shift,
	output logic                   decim_tick,
	output logic [18:0]            filter_bw_hz
);
	typedef struct packed {
		logic [7:0]  tx_deviation_ctrl;
		logic [7:0]  freq_correction_ctrl;
		logic [7:0]  channel_filter_ctrl;
		logic [7:0]  rdata;
		logic        ook;
		logic [4:0]  tx_shift;
		logic [2:0]  rx_shift;
		logic [18:0] bw;
	} regs_t;
	regs_t       st_reg;
	regs_t       st_next;
	logic [2:0]  decimation_divisor_field;
	logic [3:0]  decim_last;
	logic [2:0]  tx_exp;
	logic [1:0]  rx_exp;

	assign decimation_divisor_field = st_reg.channel_filter_ctrl[2:0];
	assign decim_last    = {1'b0, decimation_divisor_field};
	assign tx_exp        = st_reg.tx_deviation_ctrl[6:4];
	assign rx_exp        = st_reg.freq_correction_ctrl[5:4];

	always_comb begin
		st_next = st_reg;
		st_next.rdata = 8'h00;
		if (wr_en) begin
			unique case (addr)
				`OFS_TX_DEV:    st_next.tx_deviation_ctrl = wdata;
				`OFS_FREQ_CORR: st_next.freq_correction_ctrl = wdata;
				// reserved bits never stored, so they read back as zero
				`OFS_CHAN_FILT: st_next.channel_filter_ctrl = wdata & `FILT_WR_MASK;
				default:        st_next.rdata = 8'h00;
			endcase
		end
		// unmapped reads answer zero
		if (rd_en) begin
			unique case (addr)
				`OFS_TX_DEV:    st_next.rdata = st_reg.tx_deviation_ctrl;
				`OFS_FREQ_CORR: st_next.rdata = st_reg.freq_correction_ctrl;
				`OFS_CHAN_FILT: st_next.rdata = st_reg.channel_filter_ctrl;
				default:        st_next.rdata = 8'h00;
			endcase
		end
		st_next.ook = (st_reg.tx_deviation_ctrl[3:0] == 4'h0);
		// net power of two applied to fref*mantissa is exponent minus this offset
		st_next.tx_shift = upper_band ? (`TX_EXP_OFS_HI - 5'(tx_exp))
			: (`TX_EXP_OFS_LO - 5'(tx_exp));
		st_next.rx_shift = `RX_EXP_OFS - 3'(rx_exp);
		// divide the base bandwidth by the divisor, one cycle late
		st_next.bw = 19'(`FILT_BW_BASE_HZ / (19'(decimation_divisor_field) + 19'h1));
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg.tx_deviation_ctrl    <= `RST_TX_DEV;
			st_reg.freq_correction_ctrl <= `RST_FREQ_CORR;
			st_reg.channel_filter_ctrl  <= `RST_CHAN_FILT;
			st_reg.rdata                <= 8'h00;
			st_reg.ook                  <= 1'b0;
			st_reg.tx_shift             <= `RST_TX_SHIFT;
			st_reg.rx_shift             <= `RST_RX_SHIFT;
			st_reg.bw                   <= `FILT_BW_BASE_HZ;
		end else begin
			st_reg <= st_next;
		end
	end

	rate_divider u_baud (
		.clk   (clk),
		.rst_n (rst_n),
		.en_in (modem_clk_en),
		.last  (`BAUD_DIV_LAST),
		.tick  (baud_tick)
	);

	rate_divider u_decim (
		.clk   (clk),
		.rst_n (rst_n),
		.en_in (modem_clk_en),
		.last  (decim_last),
		.tick  (decim_tick)
	);

	afc_averager u_afc (
		.clk         (clk),
		.rst_n       (rst_n),
		.sample_en   (baud_tick),
		.freq_sample (freq_sample),
		.settling    (st_reg.freq_correction_ctrl[7:6]),
		.freq_avg    (freq_avg)
	);

	assign rdata                 = st_reg.rdata;
	assign gauss_shaping_on      = st_reg.tx_deviation_ctrl[7];
	assign tx_dev_mantissa       = st_reg.tx_deviation_ctrl[3:0];
	assign ook_mode              = st_reg.ook;
	assign tx_dev_shift          = st_reg.tx_shift;
	assign rx_dev_mantissa       = st_reg.freq_correction_ctrl[3:0];
	assign rx_dev_shift          = st_reg.rx_shift;
	assign analog_filter_skip    = st_reg.channel_filter_ctrl[7];
	assign decimator_input_shift = st_reg.channel_filter_ctrl[6:5];
	assign filter_bw_hz          = st_reg.bw;
endmodule : modem_cfg_regs

// ===== tb/modem_cfg_chk.sv
// assertion checker for the modem configuration bank
`timescale 1ns/100ps
module modem_cfg_chk (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [7:0]  addr,
	input wire logic [7:0]  wdata,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [7:0]  rdata,
	input wire logic        upper_band,
	input wire logic        gauss_shaping_on,
	input wire logic        ook_mode,
	input wire logic [4:0]  tx_dev_shift,
	input wire logic [3:0]  tx_dev_mantissa,
	input wire logic [2:0]  rx_dev_shift,
	input wire logic [3:0]  rx_dev_mantissa,
	input wire logic        analog_filter_skip,
	input wire logic [1:0]  decimator_input_shift,
	input wire logic [18:0] filter_bw_hz
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire w_tx = wr_en && addr == 8'h0e;
	wire w_fc = wr_en && addr == 8'h0f;
	wire w_fl = wr_en && addr == 8'h10;
	property p_gauss; w_tx |=> gauss_shaping_on == $past(wdata[7]); endproperty
	a_gauss: assert property (p_gauss) else $error("shaping bit mismatch");
	property p_txm; w_tx |=> tx_dev_mantissa == $past(wdata[3:0]); endproperty
	a_txm: assert property (p_txm) else $error("tx mantissa mismatch");
	property p_ook; w_tx |=> ##1 ook_mode == ($past(wdata[3:0], 2) == 4'h0); endproperty
	a_ook: assert property (p_ook) else $error("keying mode mismatch");
	property p_txs;
		w_tx |=> ##1 tx_dev_shift == ($past(upper_band) ? 5'h0f : 5'h10) - $past(wdata[6:4], 2);
	endproperty
	a_txs: assert property (p_txs) else $error("tx shift mismatch");
	property p_rx;
		w_fc |=> rx_dev_mantissa == $past(wdata[3:0]) ##1 rx_dev_shift == 3'h3 - $past(wdata[5:4], 2);
	endproperty
	a_rx: assert property (p_rx) else $error("rx deviation mismatch");
	property p_bw; w_fl |=> ##1 filter_bw_hz == 307200 / ($past(wdata[2:0], 2) + 32'h1); endproperty
	a_bw: assert property (p_bw) else $error("bandwidth mismatch");
	property p_skip;
		w_fl |=> analog_filter_skip == $past(wdata[7]) && decimator_input_shift == $past(wdata[6:5]);
	endproperty
	a_skip: assert property (p_skip) else $error("filter bits mismatch");
	property p_resv; rd_en && addr == 8'h10 |=> rdata[4:3] == 2'h0; endproperty
	a_resv: assert property (p_resv) else $error("reserved bits not zero");
	cover property (w_tx && wdata[3:0] == 4'h0);
	cover property (w_fl && wdata[2:0] == 3'h7);
	cover property (w_tx && upper_band);
endmodule : modem_cfg_chk
bind modem_cfg_regs modem_cfg_chk chk (
	.clk                   (clk),
	.rst_n                 (rst_n),
	.addr                  (addr),
	.wdata                 (wdata),
	.wr_en                 (wr_en),
	.rd_en                 (rd_en),
	.rdata                 (rdata),
	.upper_band            (upper_band),
	.gauss_shaping_on      (gauss_shaping_on),
	.ook_mode              (ook_mode),
	.tx_dev_shift          (tx_dev_shift),
	.tx_dev_mantissa       (tx_dev_mantissa),
	.rx_dev_shift          (rx_dev_shift),
	.rx_dev_mantissa       (rx_dev_mantissa),
	.analog_filter_skip    (analog_filter_skip),
	.decimator_input_shift (decimator_input_shift),
	.filter_bw_hz          (filter_bw_hz)
);

// ===== tb/testbench.sv
// self-checking bench for the modem configuration bank
`timescale 1ns/100ps
module testbench;
	logic        clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, upper_band = 0, modem_clk_en = 0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, t, f, c;
	logic [11:0] freq_sample = 12'h000, freq_avg;
	logic        gauss_shaping_on, ook_mode, baud_tick, analog_filter_skip, decim_tick;
	logic [4:0]  tx_dev_shift;
	logic [3:0]  tx_dev_mantissa, rx_dev_mantissa;
	logic [2:0]  rx_dev_shift;
	logic [1:0]  decimator_input_shift;
	logic [18:0] filter_bw_hz;
	int          n_mismatch = 0, checked = 0, en_n = 0, tk_n = 0;
	logic [7:0][11:0] hist = '0;
	modem_cfg_regs dut (
		.clk                   (clk),
		.rst_n                 (rst_n),
		.addr                  (addr),
		.wdata                 (wdata),
		.wr_en                 (wr_en),
		.rd_en                 (rd_en),
		.rdata                 (rdata),
		.upper_band            (upper_band),
		.modem_clk_en          (modem_clk_en),
		.freq_sample           (freq_sample),
		.gauss_shaping_on      (gauss_shaping_on),
		.ook_mode              (ook_mode),
		.tx_dev_shift          (tx_dev_shift),
		.tx_dev_mantissa       (tx_dev_mantissa),
		.rx_dev_shift          (rx_dev_shift),
		.rx_dev_mantissa       (rx_dev_mantissa),
		.baud_tick             (baud_tick),
		.freq_avg              (freq_avg),
		.analog_filter_skip    (analog_filter_skip),
		.decimator_input_shift (decimator_input_shift),
		.decim_tick            (decim_tick),
		.filter_bw_hz          (filter_bw_hz)
	);
	initial forever #4 clk = ~clk;
	always @(posedge clk) begin
		modem_clk_en <= 1'($urandom);
		freq_sample <= 12'($urandom);
		if (rst_n) begin
			en_n += modem_clk_en;
			tk_n += baud_tick;
			// mirror of the averager history, newest sample at index 0
			if (baud_tick)
				hist = {hist[6:0], freq_sample};
		end
	end
	task automatic cmp(input logic [18:0] got, input logic [18:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// mean of the newest 2, 4 or 8 samples; zero when settling is off
	function automatic logic [11:0] avg_exp(input logic [1:0] s);
		int sum;
		int n;
		sum = 0;
		n = (s == 2'h0) ? 0 : (1 << s);
		for (int k = 0; k < n; k++) begin
			sum += hist[k];
		end
		return (n == 0) ? 12'h000 : 12'(sum / n);
	endfunction : avg_exp
	// the average settles one edge after the edge that takes a sample in; the check waits two
	task automatic avg_check(input logic [1:0] s);
		@(posedge clk iff baud_tick);
		repeat (2) @(posedge clk);
		#1 cmp(freq_avg, avg_exp(s));
	endtask : avg_check
	// enables from the edge that shows one tick up to the edge before the next one shows
	task automatic period(input logic sel, input int e);
		int n;
		n = 0;
		@(posedge clk iff (sel ? decim_tick : baud_tick));
		for (int k = 0; k < 200; k++) begin
			n += modem_clk_en;
			@(posedge clk);
			if (sel ? decim_tick : baud_tick)
				break;
		end
		cmp(19'(n), 19'(e));
	endtask : period
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 cmp(rdata, e);
	endtask : rd
	// ook_mode, tx_dev_shift, rx_dev_shift and filter_bw_hz trail the register by one cycle
	task automatic derived(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
		@(posedge clk);
		#1 cmp(gauss_shaping_on, x[7]);
		cmp(tx_dev_mantissa, x[3:0]);
		cmp(ook_mode, x[3:0] == 4'h0);
		cmp(tx_dev_shift, (upper_band ? 5'h0f : 5'h10) - x[6:4]);
		cmp(rx_dev_mantissa, y[3:0]);
		cmp(rx_dev_shift, 3'h3 - y[5:4]);
		cmp({analog_filter_skip, decimator_input_shift}, z[7:5]);
		cmp(filter_bw_hz, 307200 / (z[2:0] + 1));
	endtask : derived
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	initial begin
		#100000;
		n_mismatch++;
		conclude();
	end
	initial begin
		void'($urandom(82313));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h0e, 8'he8);
		rd(8'h0f, 8'h9c);
		rd(8'h10, 8'h00);
		derived(8'he8, 8'h9c, 8'h00);
		wr(8'h11, 8'hff);
		rd(8'h11, 8'h00);
		rd(8'h10, 8'h00);
		$display("reset and unmapped test done");
		for (int i = 0; i < 40; i++) begin
			t = 8'($urandom);
			f = 8'($urandom);
			c = 8'($urandom);
			if (i < 8) begin
				// corners: on-off keying, every settling code, every divisor, reserved bits random
				t[3:0] = (i < 3) ? 4'h0 : t[3:0];
				f[7:6] = 2'(i);
				c[2:0] = 3'(i);
			end else begin
				// the rest follow the software recommendations
				t[3] = 1'b1;
				f[7:6] = 2'h3;
				// rx mantissa tracks the tx mantissa so both deviations stay in step
				f[3:0] = {1'b1, t[2:0]};
				c[6:5] = (c[2:0] <= 3'h1) ? 2'h0 : 2'h1;
				c[4:3] = 2'h0;
			end
			@(posedge clk);
			upper_band <= 1'($urandom);
			wr(8'h0e, t);
			wr(8'h0f, f);
			wr(8'h10, c);
			rd(8'h0e, t);
			rd(8'h0f, f);
			rd(8'h10, c & 8'he7);
			derived(t, f, c);
			avg_check(f[7:6]);
			period(1'b1, int'(c[2:0]) + 1);
			if (f[7:6] == 2'h0) begin
				repeat (40) @(posedge clk);
				#1 cmp(freq_avg, 12'h000);
			end
			$display("random test %0d done", i);
		end
		period(1'b0, 8);
		cmp((en_n / 8 - tk_n) inside {0, 1}, 1'b1);
		$display("tick rate test done");
		conclude();
	end
endmodule : testbench
